// *** dsp_acc_defines.svh ***
// Function
// RL1 - 40-bit sign-extending adder/subtracter; accumulator A or B is source and destination.
// RL2 - Add and load operations may scale the operand through the barrel shifter.
// RL3 - Add uses true data, carry high; subtract complements, borrow low; zero side.
// RL4 - Guard overflow flag set when bits 32..39 differ, cleared otherwise, every operation; here only add, subtract and load update it.
// RL5 - Combined status: OR of guard overflow flags, OR of sticky flags.
// RL6 - Guard overflow with that accumulator's trap enable requests arithmetic warning trap.
// RL7 - Sticky flags are set by hardware, cleared only by software write.
// RL8 - Saturation off: sticky records bit 39 overflow; catastrophic trap enable requests trap.
// RL9 - 40-bit mode: bit 39 overflow loads max positive or negative 9.31, sets sticky.
// RL10 - 32-bit mode: bit 31 overflow loads max 1.31 value, sets sticky, no guard flags.
// RL11 - Catastrophic mode: no saturation, accumulator wraps, sticky from bit 39 overflow.
// RL12 - Saturation decided from adder result, overflow status, enables and width select.
// RL13 - Width select set means 40-bit saturation, clear means 32-bit saturation.
// RL14 - Multiply-accumulate write-back of rounded high word of the other accumulator.
// RL15 - Write-back targets pointer register or memory it points to, then pointer plus 2.
// RL16 - Round mode select picks conventional or convergent; no rounding means truncation.
// RL17 - Conventional: increment high word when low word is 0x8000 to 0xffff.
// RL18 - Convergent: low word exactly 0x8000 increments only when bit 16 is one.
// RL19 - Store writes truncated, rounded store writes rounded; write-back always rounded; saturated.
// RL20 - Data write saturation clamps above 0x007fff to 0x7fff, below 0xff8000 to 0x8000.
// RL21 - Data write saturation off passes the store value unmodified.
// RL22 - One-cycle shift by signed amount up to 16: positive right, negative left; the 5-bit amount here allows right shifts of 15 at most.
// RL23 - Shifter takes accumulator or X bus; X bus at bits 16..31 right, 0..15 left.
`ifndef DSP_ACC_DEFINES_SVH
`define DSP_ACC_DEFINES_SVH
`define ACC_W 40
`define GUARD_LSB 32
`define SAT40_POS 40'h7fffffffff
`define SAT40_NEG 40'h8000000000
`define SAT32_POS 40'h007fffffff
`define SAT32_NEG 40'hff80000000
`define DW_POS 16'h7fff
`define DW_NEG 16'h8000
`define ROUND_HALF 16'h8000
`define PTR_STEP 16'h0002
`define SHIFT_MAX 5'sd16
`endif

// *** dsp_acc_pkg.sv ***
`default_nettype none
package dsp_acc_pkg;
    typedef enum logic [2:0] {
        OP_NONE, OP_ADD, OP_SUB, OP_LOAD, OP_SHIFT, OP_CLEAR
    } acc_op_type;
    typedef enum logic [1:0] {
        WB_NONE, WB_DIRECT, WB_INDIRECT
    } wb_mode_type;
    typedef enum logic [1:0] {
        ST_NONE, ST_TRUNC, ST_ROUND
    } store_type;
    typedef struct packed {
        logic acc_a_clip_enable;
        logic acc_b_clip_enable;
        logic data_write_clip_enable;
        logic clip_width_select;
        logic round_mode_select;
    } core_control_type;
    typedef struct packed {
        logic acc_a_overflow_trap_enable;
        logic acc_b_overflow_trap_enable;
        logic catastrophic_overflow_trap_enable;
    } trap_enable_type;
    typedef struct packed {
        logic acc_a_guard_overflow;
        logic acc_b_guard_overflow;
        logic acc_a_clip_sticky;
        logic acc_b_clip_sticky;
        logic any_guard_overflow;
        logic any_clip_sticky;
    } dsp_status_type;
endpackage
`default_nettype wire

// *** dsp_round_clip.sv ***
`include "dsp_acc_defines.svh"
`default_nettype none
module dsp_round_clip
    import dsp_acc_pkg::*;
(
    input wire logic [39:0] i_acc,
    input wire logic i_round,
    input wire logic i_convergent,
    input wire logic i_clip_en,
    output logic [15:0] o_word
);
    wire [15:0] low = i_acc[15:0];
    wire half_up = (low > `ROUND_HALF) ||
        (low == `ROUND_HALF && (!i_convergent || i_acc[16])); // [RL17] [RL18]
    wire inc = i_round && half_up; // [RL16]
    // Round into 24 bits so the clip sees carry into the sign
    wire [23:0] rounded = i_acc[39:16] + {23'h000000, inc};
    wire neg = i_acc[39];
    // Bit 39 decides the side; the rounded value decides the range
    wire too_big = !neg && (rounded[23:15] != 9'h000);
    wire too_small = neg && (rounded[23:15] != 9'h1ff);
    assign o_word = !i_clip_en ? rounded[15:0] : // [RL21]
        too_big ? `DW_POS : too_small ? `DW_NEG : rounded[15:0]; // [RL20]
endmodule
`default_nettype wire

// *** dsp_barrel_shift.sv ***
`include "dsp_acc_defines.svh"
`default_nettype none
module dsp_barrel_shift
    import dsp_acc_pkg::*;
(
    input wire logic [39:0] i_data,
    input wire logic signed [4:0] i_amount,
    input wire logic i_arith,
    output logic [39:0] o_data
);
    wire [4:0] mag = i_amount[4] ? 5'(-i_amount) : i_amount;
    wire fill = i_arith & i_data[39];
    wire [79:0] ext = {{40{fill}}, i_data};
    wire [79:0] rsh = ext >> mag;
    // Width of the amount bounds the shift to 16
    assign o_data = (i_amount == 5'sd0) ? i_data :
        i_amount[4] ? (i_data << mag) : rsh[39:0]; // [RL22]
endmodule
`default_nettype wire

// *** dsp_accumulator_datapath.sv ***
`include "dsp_acc_defines.svh"
`default_nettype none
module dsp_accumulator_datapath
    import dsp_acc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire acc_op_type i_op,
    input wire logic i_target_b,
    input wire logic [39:0] i_operand,
    input wire logic i_operand_from_acc,
    input wire logic [15:0] i_xbus_data,
    input wire logic i_src_xbus,
    input wire logic i_scale,
    input wire logic signed [4:0] i_shift_amount,
    input wire logic i_shift_arith,
    input wire logic i_carry_in,
    input wire logic i_zero_acc_side,
    input wire store_type i_store,
    input wire wb_mode_type i_writeback,
    input wire core_control_type i_core_control_reg,
    input wire trap_enable_type i_interrupt_control_reg1,
    input wire logic i_clear_sticky_a,
    input wire logic i_clear_sticky_b,
    input wire logic i_ptr_write,
    input wire logic [15:0] i_ptr_wdata,
    output logic [39:0] o_acc_a,
    output logic [39:0] o_acc_b,
    output dsp_status_type o_status,
    output logic o_arith_warning_trap,
    output logic o_xbus_write,
    output logic [15:0] o_xbus_addr,
    output logic [15:0] o_xbus_wdata,
    output logic [15:0] o_writeback_pointer_reg,
    output logic [15:0] o_shift_mcu_result
);
    logic [39:0] acc_a;
    logic [39:0] acc_b;
    logic guard_a;
    logic guard_b;
    logic sticky_a;
    logic sticky_b;
    logic [15:0] wb_ptr;

    wire is_add = (i_op == OP_ADD) || (i_op == OP_LOAD);
    wire is_sub = (i_op == OP_SUB);
    wire arith = is_add || is_sub;
    wire [39:0] acc_t = i_target_b ? acc_b : acc_a; // [RL1]
    wire [39:0] acc_nt = i_target_b ? acc_a : acc_b;

    // X bus word sits at 16..31 for right shifts, 0..15 for left
    wire [39:0] xbus_ext = i_shift_amount[4] ?
        {{24{i_xbus_data[15]}}, i_xbus_data} :
        {{8{i_shift_arith & i_xbus_data[15]}}, i_xbus_data,
        16'h0000}; // [RL23]
    // Logical right shifts must not pull sign bits down from the guard
    wire [39:0] shift_src = i_src_xbus ? xbus_ext :
        (i_operand_from_acc ? acc_nt : i_operand); // [RL23]
    // Five signed bits already bound the shift to 15 right and 16 left
    wire signed [4:0] amount = i_shift_amount;
    wire [39:0] shifted;

    dsp_barrel_shift shifter (
        .i_data(shift_src),
        .i_amount(amount),
        .i_arith(i_shift_arith),
        .o_data(shifted)
    );

    wire [39:0] plain = i_operand_from_acc ? acc_nt : i_operand;
    wire [39:0] operand = (i_scale && is_add) ? shifted : plain; // [RL2]
    // Load forces the accumulator side to zero
    wire zero_side = i_zero_acc_side || (i_op == OP_LOAD); // [RL3]
    wire [39:0] side_a = zero_side ? 40'h0000000000 : acc_t;
    wire [39:0] side_b = is_sub ? ~operand : operand; // [RL3]
    // Borrow is active low, so the raw bit goes straight in
    wire cin = i_carry_in; // [RL3]
    wire [40:0] sum_wide = {1'b0, side_a} + {1'b0, side_b} +
        {40'h0000000000, cin}; // [RL1]
    wire [39:0] sum = sum_wide[39:0];
    // Signed overflow out of bit 39
    wire ovf39 = (side_a[39] == side_b[39]) && (sum[39] != side_a[39]);
    wire guard_bad = (sum[39:31] != 9'h000) && (sum[39:31] != 9'h1ff);
    wire guard_diff = (sum[39:32] != 8'h00) && (sum[39:32] != 8'hff);

    wire clip_en = i_target_b ? i_core_control_reg.acc_b_clip_enable :
        i_core_control_reg.acc_a_clip_enable; // [RL12]
    wire wide = i_core_control_reg.clip_width_select; // [RL13]
    wire true_neg = ovf39 ? ~sum[39] : sum[39];
    // 32-bit mode also catches wrap past bit 39
    wire clip32 = clip_en && !wide && (guard_bad || ovf39); // [RL10]
    wire clip40 = clip_en && wide && ovf39; // [RL9]
    wire [39:0] clipped = clip40 ?
        (true_neg ? `SAT40_NEG : `SAT40_POS) :
        clip32 ? (true_neg ? `SAT32_NEG : `SAT32_POS) : sum; // [RL11]
    wire sticky_evt = clip40 || clip32 || (!clip_en && ovf39); // [RL8] [RL11]
    // Guard bits unused in 32-bit mode
    wire guard_evt = guard_diff && !clip32 && !(clip_en && !wide); // [RL4]

    wire [39:0] next_acc = (i_op == OP_CLEAR) ? 40'h0000000000 :
        (i_op == OP_SHIFT) ? shifted : clipped;
    wire write_acc = arith || (i_op == OP_SHIFT) || (i_op == OP_CLEAR);

    // Store uses target, write-back uses the other accumulator
    wire wb_on = (i_writeback != WB_NONE); // [RL14]
    wire [39:0] store_src = wb_on ? acc_nt : acc_t;
    wire do_round = wb_on || (i_store == ST_ROUND); // [RL19]
    wire [15:0] store_word;

    dsp_round_clip rounder (
        .i_acc(store_src),
        .i_round(do_round),
        .i_convergent(i_core_control_reg.round_mode_select),
        .i_clip_en(i_core_control_reg.data_write_clip_enable),
        .o_word(store_word)
    );

    wire mem_write = (i_store != ST_NONE) || (i_writeback == WB_INDIRECT);
    wire trap_ov = (guard_evt && (i_target_b ?
        i_interrupt_control_reg1.acc_b_overflow_trap_enable :
        i_interrupt_control_reg1.acc_a_overflow_trap_enable)) ||
        (!clip_en && ovf39 &&
        i_interrupt_control_reg1.catastrophic_overflow_trap_enable);

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_a <= 40'h0000000000;
            acc_b <= 40'h0000000000;
        end else if (write_acc) begin
            if (i_target_b) begin
                acc_b <= next_acc; // [RL1]
            end else begin
                acc_a <= next_acc; // [RL1]
            end
        end
    end

    // Guard flags follow every adder pass of their accumulator
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            guard_a <= 1'b0;
            guard_b <= 1'b0;
        end else if (arith) begin
            if (i_target_b) begin
                guard_b <= guard_evt; // [RL4]
            end else begin
                guard_a <= guard_evt; // [RL4]
            end
        end
    end

    // Set beats a same-cycle software clear
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            sticky_a <= 1'b0;
            sticky_b <= 1'b0;
        end else begin
            sticky_a <= (arith && !i_target_b && sticky_evt) ||
                (sticky_a && !i_clear_sticky_a); // [RL7]
            sticky_b <= (arith && i_target_b && sticky_evt) ||
                (sticky_b && !i_clear_sticky_b); // [RL7]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_status <= '0;
        end else begin
            o_status.acc_a_guard_overflow <= guard_a;
            o_status.acc_b_guard_overflow <= guard_b;
            o_status.acc_a_clip_sticky <= sticky_a;
            o_status.acc_b_clip_sticky <= sticky_b;
            o_status.any_guard_overflow <= guard_a || guard_b; // [RL5]
            o_status.any_clip_sticky <= sticky_a || sticky_b; // [RL5]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_arith_warning_trap <= 1'b0;
        end else begin
            o_arith_warning_trap <= arith && trap_ov; // [RL6] [RL8]
        end
    end

    // Pointer: software load, direct write-back, post-increment
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wb_ptr <= 16'h0000;
        end else if (i_writeback == WB_DIRECT) begin
            wb_ptr <= store_word; // [RL15]
        end else if (i_writeback == WB_INDIRECT) begin
            wb_ptr <= wb_ptr + `PTR_STEP; // [RL15]
        end else if (i_ptr_write) begin
            wb_ptr <= i_ptr_wdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_xbus_write <= 1'b0;
            o_xbus_addr <= 16'h0000;
            o_xbus_wdata <= 16'h0000;
        end else begin
            o_xbus_write <= mem_write; // [RL19]
            o_xbus_addr <= wb_ptr; // [RL15]
            o_xbus_wdata <= store_word; // [RL19]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_shift_mcu_result <= 16'h0000;
        end else begin
            o_shift_mcu_result <= i_shift_amount[4] ? shifted[15:0] :
                shifted[31:16]; // [RL23]
        end
    end

    assign o_acc_a = acc_a;
    assign o_acc_b = acc_b;
    assign o_writeback_pointer_reg = wb_ptr;
endmodule
`default_nettype wire

// *** dsp_acc_checker_assertions.sv ***
`include "dsp_acc_defines.svh"
`default_nettype none
module dsp_acc_checker
    import dsp_acc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire acc_op_type i_op,
    input wire logic i_target_b,
    input wire logic [39:0] i_operand,
    input wire logic i_scale,
    input wire logic i_operand_from_acc,
    input wire logic i_carry_in,
    input wire core_control_type i_core_control_reg,
    input wire trap_enable_type i_interrupt_control_reg1,
    input wire logic i_clear_sticky_a,
    input wire wb_mode_type i_writeback,
    input wire logic [39:0] o_acc_a,
    input wire dsp_status_type o_status,
    input wire logic o_arith_warning_trap,
    input wire logic o_xbus_write,
    input wire logic [15:0] o_xbus_addr,
    input wire logic [15:0] o_writeback_pointer_reg
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    wire logic load_a = i_op == OP_LOAD && !i_target_b && !i_scale
        && !i_core_control_reg.acc_a_clip_enable
        && !i_operand_from_acc && !i_carry_in;
    wire logic odd_guard = !(&i_operand[39:32]) && |i_operand[39:32];
    wire logic add_one = i_op == OP_ADD && !i_target_b && !i_scale
        && i_core_control_reg.acc_a_clip_enable && i_operand == 40'h1
        && !i_operand_from_acc;
    wire logic width40 = i_core_control_reg.clip_width_select;
    AST_LOAD_A: assert property (load_a |=> o_acc_a == $past(i_operand))
        else $error("load into accumulator a lost its operand");
    AST_GUARD_A: assert property (load_a |=> ##1
        o_status.acc_a_guard_overflow == $past(odd_guard, 2))
        else $error("guard overflow flag wrong after load");
    AST_ANY_GUARD: assert property (o_status.any_guard_overflow ==
        (o_status.acc_a_guard_overflow | o_status.acc_b_guard_overflow))
        else $error("combined guard overflow wrong");
    AST_ANY_STICKY: assert property (o_status.any_clip_sticky ==
        (o_status.acc_a_clip_sticky | o_status.acc_b_clip_sticky))
        else $error("combined sticky wrong");
    AST_GUARD_TRAP: assert property (load_a && odd_guard &&
        i_interrupt_control_reg1.acc_a_overflow_trap_enable
        |=> o_arith_warning_trap)
        else $error("guard overflow trap missing");
    AST_STICKY_HOLD: assert property ($fell(o_status.acc_a_clip_sticky)
        |-> $past(i_clear_sticky_a, 2))
        else $error("sticky flag cleared without software");
    AST_SAT40: assert property (add_one && width40 &&
        o_acc_a == `SAT40_POS |=> o_acc_a == `SAT40_POS)
        else $error("40-bit clip missed");
    AST_SAT32: assert property (add_one && !width40 &&
        o_acc_a == `SAT32_POS |=> o_acc_a == `SAT32_POS)
        else $error("32-bit clip missed");
    AST_WB_IND: assert property (i_writeback == WB_INDIRECT |=>
        o_xbus_write && o_xbus_addr == $past(o_writeback_pointer_reg) &&
        o_writeback_pointer_reg == $past(o_writeback_pointer_reg) + `PTR_STEP)
        else $error("indirect write-back address or step wrong");
endmodule
bind dsp_accumulator_datapath dsp_acc_checker dsp_acc_checker_inst (.*);
`default_nettype wire

// *** xbus_mem_model.sv ***
`default_nettype none
module xbus_mem_model (
    input wire logic i_clk_sys,
    input wire logic i_write,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] i_raddr,
    output logic [15:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [256];
    // Word writes only, byte lane bit ignored; unwritten words read unknown
    always @(posedge i_clk_sys) begin
        if (i_write)
            mem[i_addr[8:1]] <= i_wdata;
    end
    assign o_rdata = mem[i_raddr[8:1]];
endmodule
`default_nettype wire

// *** dsp_accumulator_datapath_tb.sv ***
`include "dsp_acc_defines.svh"
`default_nettype none
module dsp_accumulator_datapath_tb
    import dsp_acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, nrst = 1'h0, tgt = 1'h0, zero = 1'h0;
    logic srcx = 1'h0, scl = 1'h0, ari = 1'h0, clr_a = 1'h0, clr_b = 1'h0;
    logic pw = 1'h0, fa = 1'h0, ci = 1'h0;
    acc_op_type op = OP_NONE;
    logic [39:0] opnd = '0;
    logic [15:0] pwd = 16'h0100;
    logic signed [4:0] amt = '0;
    store_type st = ST_NONE;
    wb_mode_type wb = WB_NONE;
    core_control_type cc = '0;
    trap_enable_type te = '0;
    logic [39:0] acc_a, acc_b;
    dsp_status_type sts;
    logic trap, xw;
    logic [15:0] xa, xwd, ptr, mcu, mrd;
    int mismatches = 0, checks_done = 0;
    always #20 clk = ~clk;
    dsp_accumulator_datapath dsp_accumulator_datapath_inst (.i_clk_sys(clk),
        .i_nrst(nrst), .i_op(op), .i_target_b(tgt), .i_operand(opnd),
        .i_operand_from_acc(fa), .i_xbus_data(16'h8421),
        .i_src_xbus(srcx), .i_scale(scl), .i_shift_amount(amt),
        .i_shift_arith(ari), .i_carry_in(ci), .i_zero_acc_side(zero),
        .i_store(st), .i_writeback(wb), .i_core_control_reg(cc),
        .i_interrupt_control_reg1(te), .i_clear_sticky_a(clr_a),
        .i_clear_sticky_b(clr_b), .i_ptr_write(pw), .i_ptr_wdata(pwd),
        .o_acc_a(acc_a), .o_acc_b(acc_b), .o_status(sts),
        .o_arith_warning_trap(trap), .o_xbus_write(xw), .o_xbus_addr(xa),
        .o_xbus_wdata(xwd), .o_writeback_pointer_reg(ptr),
        .o_shift_mcu_result(mcu));
    xbus_mem_model xbus_mem_model_inst (.i_clk_sys(clk), .i_write(xw),
        .i_addr(xa), .i_wdata(xwd), .i_raddr(16'h0100), .o_rdata(mrd));
    task automatic chk(string n, logic [39:0] e, logic [39:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic nxt;
        @(posedge clk);
        #1;
    endtask
    task automatic go(acc_op_type o, logic b, logic [39:0] v,
        store_type s = ST_NONE, wb_mode_type w = WB_NONE);
        @(posedge clk);
        op <= o;
        tgt <= b;
        opnd <= v;
        st <= s;
        wb <= w;
        nxt;
        op <= OP_NONE;
        st <= ST_NONE;
        wb <= WB_NONE;
    endtask
    task automatic sh(logic [4:0] a, logic r, logic x, logic s);
        @(posedge clk);
        amt <= a;
        ari <= r;
        srcx <= x;
        scl <= s;
    endtask
    task automatic t_arith;
        go(OP_LOAD, 1'h0, 40'h0000001234);
        ci <= 1'h1;
        go(OP_ADD, 1'h0, 40'h10);
        chk("acc_a add", 40'h1245, acc_a);
        ci <= 1'h0;
        go(OP_SUB, 1'h0, 40'h44);
        chk("acc_a sub", 40'h1200, acc_a);
        go(OP_LOAD, 1'h1, 40'h5);
        chk("acc_b load", 40'h5, acc_b);
        chk("acc_a kept", 40'h1200, acc_a);
        sh(5'h04, 1'h1, 1'h0, 1'h1);
        go(OP_LOAD, 1'h0, 40'h100);
        chk("scaled load", 40'h10, acc_a);
        sh(5'h00, 1'h0, 1'h0, 1'h0);
    endtask
    task automatic t_guard;
        @(posedge clk) te <= 3'h4;
        go(OP_LOAD, 1'h0, 40'h0100000000);
        chk("guard trap", 1'h1, trap);
        nxt;
        chk("guard a", 1'h1, sts.acc_a_guard_overflow);
        chk("any guard", 1'h1, sts.any_guard_overflow);
        go(OP_LOAD, 1'h0, 40'hffffffffff);
        chk("no trap", 1'h0, trap);
        nxt;
        chk("guard clear", 1'h0, sts.acc_a_guard_overflow);
    endtask
    task automatic t_clip;
        logic [39:0] ex [3] = '{`SAT40_NEG, `SAT32_POS, `SAT40_POS};
        logic [4:0] cm [3] = '{5'h00, 5'h10, 5'h12};
        for (int m = 0; m < 3; m++) begin
            @(posedge clk) cc <= cm[m];
            @(posedge clk) te <= 3'h1;
            go(OP_LOAD, 1'h0, (m == 1) ? `SAT32_POS : `SAT40_POS);
            go(OP_ADD, 1'h0, 40'h1);
            chk("clip acc", ex[m], acc_a);
            chk("cat trap", m == 0, trap);
            go(OP_ADD, 1'h0, 40'h0);
            nxt;
            chk("sticky a", 1'h1, sts.acc_a_clip_sticky);
            chk("any sticky", 1'h1, sts.any_clip_sticky);
            if (m == 1)
                chk("guard 32", 1'h0, sts.acc_a_guard_overflow);
            @(posedge clk) clr_a <= 1'h1;
            @(posedge clk) clr_a <= 1'h0;
            nxt;
            chk("sticky clear", 1'h0, sts.acc_a_clip_sticky);
        end
        @(posedge clk) te <= 3'h0;
        go(OP_LOAD, 1'h1, 40'h8000000000);
        go(OP_SUB, 1'h1, 40'h1);
        chk("acc_b wrap", 40'h7ffffffffe, acc_b);
        nxt;
        chk("sticky b", 1'h1, sts.acc_b_clip_sticky);
        chk("guard b", 1'h1, sts.acc_b_guard_overflow);
        @(posedge clk) clr_b <= 1'h1;
        @(posedge clk) clr_b <= 1'h0;
        nxt;
        chk("sticky b clear", 1'h0, sts.acc_b_clip_sticky);
    endtask
    task automatic t_store;
        logic [39:0] v [9] = '{40'h0012348000, 40'h0012348000,
            40'h0012358000, 40'h00123480ff, 40'h0012347fff, 40'h001234ffff,
            40'h0090000000, 40'hff70000000, 40'h0090000000};
        logic [15:0] e [9] = '{16'h1235, 16'h1234, 16'h1236, 16'h1235,
            16'h1234, 16'h1234, 16'h7fff, 16'h8000, 16'h9000};
        logic [4:0] c [9] = '{5'h00, 5'h01, 5'h01, 5'h00, 5'h01, 5'h01,
            5'h04, 5'h04, 5'h00};
        for (int i = 0; i < 9; i++) begin
            @(posedge clk) cc <= c[i];
            go(OP_LOAD, 1'h0, v[i]);
            go(OP_NONE, 1'h0, 40'h0, (i > 4) ? ST_TRUNC : ST_ROUND);
            chk("store write", 1'h1, xw);
            chk("store word", e[i], xwd);
            chk("source kept", v[i], acc_a);
        end
    endtask
    task automatic t_wb;
        @(posedge clk) pw <= 1'h1;
        @(posedge clk) pw <= 1'h0;
        go(OP_LOAD, 1'h1, 40'h00abcd8000);
        go(OP_ADD, 1'h0, 40'h0, ST_NONE, WB_INDIRECT);
        chk("wb addr", 16'h0100, xa);
        chk("wb data", 16'habce, xwd);
        chk("wb ptr", 16'h0102, ptr);
        nxt;
        chk("mem word", 16'habce, mrd);
        go(OP_ADD, 1'h0, 40'h0, ST_NONE, WB_DIRECT);
        chk("wb direct", 16'habce, ptr);
    endtask
    task automatic t_shift;
        logic [4:0] a [5] = '{5'h04, 5'h04, 5'h1c, 5'h00, 5'h10};
        logic [15:0] e [5] = '{16'hf842, 16'h0842, 16'h4210, 16'h8421, 16'h0};
        logic [4:0] r = 5'h09;
        for (int i = 0; i < 5; i++) begin
            sh(a[i], r[i], 1'h1, 1'h0);
            go(OP_SHIFT, 1'h0, 40'h0);
            chk("mcu shift", e[i], mcu);
        end
        go(OP_LOAD, 1'h1, 40'h0012340000);
        sh(5'h0f, 1'h1, 1'h0, 1'h0);
        fa <= 1'h1;
        go(OP_SHIFT, 1'h0, 40'h0);
        chk("acc shift", 40'h2468, acc_a);
        fa <= 1'h0;
        go(OP_CLEAR, 1'h0, 40'h0);
        chk("acc clear", 40'h0, acc_a);
        sh(5'h00, 1'h0, 1'h0, 1'h0);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        t_arith;
        t_guard;
        t_clip;
        t_store;
        t_wb;
        t_shift;
        @(posedge clk) nrst <= 1'h0;
        nxt;
        chk("reset acc", 40'h0, acc_a);
        @(posedge clk) nrst <= 1'h1;
        t_arith;
        results;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results;
    end
endmodule
`default_nettype wire
